//--- shared/xps_defs.svh
// Purpose: constants shared by both ends of the crosspoint serial configuration port
// Assumes: 200 MHz core clock on both ends
// Notes:   frame, word and register layouts; timing counts derived from nanoseconds
`ifndef XPS_DEFS_SVH
`define XPS_DEFS_SVH

// ----------------------------------------------------------------
// frame and word layout
// ----------------------------------------------------------------
`define XPS_FRAME_W 16
`define XPS_WORD_W 6
`define XPS_OUT_N 4
`define XPS_SEL_W 3
`define XPS_FLD_W 4
`define XPS_WORD_BASE 10
`define XPS_W_OIDX_LO 0
`define XPS_W_SEL_LO 2
`define XPS_W_OFF 5
`define XPS_ROUTE_OFF 4'h8
`define XPS_ROUTE_BCAST 4'h0
`define XPS_FRAME_ZERO 16'h0000
`define XPS_BCNT_W 3
`define XPS_BCNT_ZERO 3'h0
`define XPS_BCNT_ONE 3'h1
`define XPS_BCNT_WORD 3'h6

// ----------------------------------------------------------------
// synchroniser bit positions
// ----------------------------------------------------------------
`define XPS_SYNC_W 7
`define XPS_S_CS 6
`define XPS_S_SCLK 5
`define XPS_S_DIN 4
`define XPS_S_CFG 3
`define XPS_S_MODE 2
`define XPS_S_RST 1
`define XPS_S_BCAST 0
`define XPS_SYNC_ZERO 7'h00
`define XPS_SYNC_IDLE 7'h48

// ----------------------------------------------------------------
// controller timing
// ----------------------------------------------------------------
`define XPS_CLK_NS 5
`define XPS_SCLK_NS 80
`define XPS_HALF_CYC ((`XPS_SCLK_NS / 2) / `XPS_CLK_NS)
`define XPS_TMR_W 4
`define XPS_TMR_ZERO 4'h0
`define XPS_TMR_ONE 4'h1

// ----------------------------------------------------------------
// controller registers (word index on the Avalon address)
// ----------------------------------------------------------------
`define XPS_ADDR_W 3
`define XPS_REG_CTRL 3'h0
`define XPS_REG_DATA 3'h1
`define XPS_REG_CMD 3'h2
`define XPS_REG_STAT 3'h3
`define XPS_REG_RX 3'h4
`define XPS_CTRL_MODE 0
`define XPS_CTRL_RST 1
`define XPS_CTRL_BCAST 2
`define XPS_CTRL_3WIRE 3
`define XPS_CTRL_W 4
`define XPS_CTRL_RESET 4'h0
`define XPS_CMD_NB_HI 5
`define XPS_CMD_SHIFT 8
`define XPS_CMD_CFG 9
`define XPS_NB_W 6
`define XPS_NB_ZERO 6'h00
`define XPS_NB_ONE 6'h01
`define XPS_NB_MAX 6'h20
`define XPS_WORD32_ZERO 32'h00000000

`endif

//--- shared/xps_pkg.sv
// Purpose: types shared by both ends of the crosspoint serial configuration port
// Assumes: xps_defs.svh on the include path
// Notes:   route entry packs as {off, sel}, the same order as a frame field
`include "xps_defs.svh"
package xps_pkg;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic off;
      logic [`XPS_SEL_W-1:0] sel;
   } xps_route_t;

   typedef enum logic [2:0]
   {
      XPS_IDLE  = 3'h0,
      XPS_LEAD  = 3'h1,
      XPS_SHIFT = 3'h3,
      XPS_TRAIL = 3'h2,
      XPS_TAIL  = 3'h6,
      XPS_CFG   = 3'h7
   } xps_state_t;

endpackage

//--- shared/xps_if.sv
// Purpose: serial control pins between controller and crosspoint
// Assumes: all pins single-direction, no shared wires
// Notes:   controller drives everything but dout
`timescale 1ns/10ps
`default_nettype none
interface xps_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic cfg;
   logic mode;
   logic rst;
   logic broadcast_input0;

   modport dev
   (
      input cs_n,
      input sclk,
      input din,
      input cfg,
      input mode,
      input rst,
      input broadcast_input0,
      output dout
   );

   modport host
   (
      output cs_n,
      output sclk,
      output din,
      output cfg,
      output mode,
      output rst,
      output broadcast_input0,
      input dout
   );
endinterface
`default_nettype wire

//--- rtl/xps_dev.sv
// Purpose: crosspoint end of the serial configuration port (shadow and active routing banks)
// Assumes: link pins are asynchronous to core_clk and slow enough to oversample
// Notes:   route_q is what the switch matrix would use
`timescale 1ns/10ps
`default_nettype none
`include "xps_defs.svh"
module xps_dev
   import xps_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   xps_if.dev link,
   output xps_route_t [`XPS_OUT_N-1:0] route_q,
   output logic [`XPS_FRAME_W-1:0] shadow_q,
   output logic fresh_q
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [`XPS_SYNC_W-1:0] pins_raw;
   logic [`XPS_SYNC_W-1:0] meta_q;
   logic [`XPS_SYNC_W-1:0] sync_q;
   logic sclk_d1_q;
   logic cfg_d1_q;
   logic cs_s;
   logic din_s;
   logic mode_s;
   logic rst_s;
   logic bcast_s;
   logic rise;
   logic fall;
   logic cfg_rise;

   assign pins_raw = {link.cs_n, link.sclk, link.din, link.cfg, link.mode, link.rst, link.broadcast_input0};

   // select idles high so nothing is armed while reset releases
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= `XPS_SYNC_IDLE;
         sync_q <= `XPS_SYNC_IDLE;
      end
      else
      begin
         meta_q <= pins_raw;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_d1_q <= 1'b0;
         // same level as the synchroniser's idle strobe, so reset release shows no false rise
         cfg_d1_q <= 1'b1;
      end
      else
      begin
         sclk_d1_q <= sync_q[`XPS_S_SCLK];
         cfg_d1_q <= sync_q[`XPS_S_CFG];
      end
   end

   assign cs_s = sync_q[`XPS_S_CS];
   assign din_s = sync_q[`XPS_S_DIN];
   assign mode_s = sync_q[`XPS_S_MODE];
   assign rst_s = sync_q[`XPS_S_RST];
   assign bcast_s = sync_q[`XPS_S_BCAST];
   assign rise = sync_q[`XPS_S_SCLK] & ~sclk_d1_q;
   assign fall = ~sync_q[`XPS_S_SCLK] & sclk_d1_q;
   assign cfg_rise = sync_q[`XPS_S_CFG] & ~cfg_d1_q;

   // ----------------------------------------------------------------
   // arming and bit count
   // ----------------------------------------------------------------
   logic armed_q;
   logic [`XPS_BCNT_W-1:0] bcnt_q;
   logic shift;

   // arming looks at select only on a rising edge; a fall before any rise shifts nothing
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         armed_q <= 1'b0;
      end
      else if (rise)
      begin
         armed_q <= ~cs_s;
      end
   end

   // addressed mode stops after one word; only a rise with select high restarts the count,
   // so a host that skips that rise loses the following word
   assign shift = fall & armed_q & ~cs_s & (~mode_s | (bcnt_q != `XPS_BCNT_WORD));

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bcnt_q <= `XPS_BCNT_ZERO;
      end
      else if (rise && cs_s)
      begin
         bcnt_q <= `XPS_BCNT_ZERO;
      end
      else if (shift && mode_s && bcnt_q != `XPS_BCNT_WORD)
      begin
         bcnt_q <= bcnt_q + `XPS_BCNT_ONE;
      end
   end

   // ----------------------------------------------------------------
   // shadow bank and serial out
   // ----------------------------------------------------------------
   logic dout_q;

   // bit 0 enters first and ends in the lowest position after a full frame
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shadow_q <= `XPS_FRAME_ZERO;
      end
      else if (shift)
      begin
         shadow_q <= {din_s, shadow_q[`XPS_FRAME_W-1:1]};
      end
   end

   // serial out changes on the rise, half a period before the next stage samples it
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dout_q <= 1'b0;
      end
      else if (mode_s)
      begin
         dout_q <= 1'b0;
      end
      else if (rise && !cs_s)
      begin
         dout_q <= shadow_q[0];
      end
   end

   assign link.dout = dout_q;

   // ----------------------------------------------------------------
   // commit of shadow to active bank
   // ----------------------------------------------------------------
   logic commit;
   logic [1:0] word_oidx;
   xps_route_t word_route;

   assign commit = cfg_rise & fresh_q;

   // a new shift in the commit cycle keeps the flag set
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fresh_q <= 1'b0;
      end
      else if (shift)
      begin
         fresh_q <= 1'b1;
      end
      else if (commit)
      begin
         fresh_q <= 1'b0;
      end
   end

   // the six-bit word lands in the top of the shadow register
   assign word_oidx = shadow_q[`XPS_WORD_BASE + `XPS_W_OIDX_LO +: 2];
   assign word_route.sel = shadow_q[`XPS_WORD_BASE + `XPS_W_SEL_LO +: `XPS_SEL_W];
   assign word_route.off = shadow_q[`XPS_WORD_BASE + `XPS_W_OFF];

   // ----------------------------------------------------------------
   // active routing bank, one register per output
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `XPS_OUT_N; gi = gi + 1)
      begin : g_out
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               route_q[gi] <= `XPS_ROUTE_OFF;
            end
            else if (rst_s)
            begin
               route_q[gi] <= `XPS_ROUTE_OFF;
            end
            else if (bcast_s)
            begin
               route_q[gi] <= `XPS_ROUTE_BCAST;
            end
            else if (commit && !mode_s)
            begin
               route_q[gi] <= shadow_q[gi * `XPS_FLD_W +: `XPS_FLD_W];
            end
            else if (commit && mode_s && word_oidx == 2'(gi))
            begin
               route_q[gi] <= word_route;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

//--- rtl/xps_host.sv
// Purpose: controller end; drives the serial pins on orders from an Avalon-MM slave
// Assumes: software waits for busy low before reading back shifted-out data
// Notes:   serial clock made by dividing core_clk; registers at word indexes
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "xps_defs.svh"
module xps_host
   import xps_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   xps_if.host link,
   input wire logic [`XPS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   xps_state_t state_q;
   logic [`XPS_CTRL_W-1:0] ctrl_q;
   logic [31:0] data_q;
   logic [31:0] rx_q;
   logic [`XPS_NB_W-1:0] nbits_q;
   logic [`XPS_NB_W-1:0] cnt_q;
   logic cfg_want_q;
   logic rd_valid_q;
   logic cmd_wr;
   logic busy;
   logic [`XPS_NB_W-1:0] nb_in;

   assign busy = (state_q != XPS_IDLE);
   assign cmd_wr = avs_write & (avs_address == `XPS_REG_CMD) & ~busy;
   assign nb_in = (avs_writedata[`XPS_CMD_NB_HI:0] > `XPS_NB_MAX) ? `XPS_NB_MAX : avs_writedata[`XPS_CMD_NB_HI:0];
   // a command while busy is stalled rather than dropped
   assign avs_waitrequest = (avs_write & (avs_address == `XPS_REG_CMD) & busy) | (avs_read & ~rd_valid_q);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= `XPS_CTRL_RESET;
         data_q <= `XPS_WORD32_ZERO;
      end
      else if (avs_write && avs_address == `XPS_REG_CTRL)
      begin
         ctrl_q <= avs_writedata[`XPS_CTRL_W-1:0];
      end
      else if (avs_write && avs_address == `XPS_REG_DATA)
      begin
         data_q <= avs_writedata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_valid_q <= 1'b0;
         avs_readdata <= `XPS_WORD32_ZERO;
      end
      else
      begin
         rd_valid_q <= avs_read & ~rd_valid_q;
         case (avs_address)
            `XPS_REG_CTRL: avs_readdata <= {28'h0000000, ctrl_q};
            `XPS_REG_DATA: avs_readdata <= data_q;
            `XPS_REG_CMD: avs_readdata <= {26'h0000000, nbits_q};
            `XPS_REG_STAT: avs_readdata <= {31'h00000000, busy};
            `XPS_REG_RX: avs_readdata <= rx_q;
            default: avs_readdata <= `XPS_WORD32_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // serial sequencer
   // ----------------------------------------------------------------
   logic [`XPS_TMR_W-1:0] tmr_q;
   logic tick;
   logic sclk_q;
   logic cs_n_q;
   logic din_q;
   logic cfg_q;
   logic meta_q;
   logic dout_s_q;

   assign tick = (tmr_q == `XPS_TMR_W'(`XPS_HALF_CYC - 1));

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr_q <= `XPS_TMR_ZERO;
      end
      else if (!busy || tick)
      begin
         tmr_q <= `XPS_TMR_ZERO;
      end
      else
      begin
         tmr_q <= tmr_q + `XPS_TMR_ONE;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= 1'b0;
         dout_s_q <= 1'b0;
      end
      else
      begin
         meta_q <= link.dout;
         dout_s_q <= meta_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= XPS_IDLE;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         din_q <= 1'b0;
         cfg_q <= 1'b0;
         cnt_q <= `XPS_NB_ZERO;
         nbits_q <= `XPS_NB_ZERO;
         cfg_want_q <= 1'b0;
         rx_q <= `XPS_WORD32_ZERO;
      end
      else
      begin
         case (state_q)
            XPS_IDLE:
            begin
               if (cmd_wr)
               begin
                  nbits_q <= nb_in;
                  cfg_want_q <= avs_writedata[`XPS_CMD_CFG];
                  cnt_q <= `XPS_NB_ZERO;
                  din_q <= data_q[0];
                  if (avs_writedata[`XPS_CMD_SHIFT] && nb_in != `XPS_NB_ZERO)
                  begin
                     cs_n_q <= 1'b0;
                     state_q <= XPS_LEAD;
                  end
                  else if (avs_writedata[`XPS_CMD_CFG])
                  begin
                     state_q <= XPS_CFG;
                  end
               end
            end
            XPS_LEAD:
            begin
               if (tick)
               begin
                  sclk_q <= 1'b1;
                  state_q <= XPS_SHIFT;
               end
            end
            XPS_SHIFT:
            begin
               if (tick && !sclk_q)
               begin
                  sclk_q <= 1'b1;
                  din_q <= data_q[cnt_q[4:0]];
               end
               else if (tick)
               begin
                  sclk_q <= 1'b0;
                  rx_q <= {dout_s_q, rx_q[31:1]};
                  cnt_q <= cnt_q + `XPS_NB_ONE;
                  if (cnt_q + `XPS_NB_ONE == nbits_q)
                  begin
                     state_q <= XPS_TRAIL;
                  end
               end
            end
            XPS_TRAIL:
            begin
               cs_n_q <= 1'b1;
               if (tick)
               begin
                  if (ctrl_q[`XPS_CTRL_MODE])
                  begin
                     state_q <= XPS_TAIL;
                  end
                  else if (cfg_want_q && !ctrl_q[`XPS_CTRL_3WIRE])
                  begin
                     state_q <= XPS_CFG;
                  end
                  else
                  begin
                     state_q <= XPS_IDLE;
                  end
               end
            end
            XPS_TAIL:
            begin
               if (tick && !sclk_q)
               begin
                  sclk_q <= 1'b1;
               end
               else if (tick)
               begin
                  sclk_q <= 1'b0;
                  state_q <= (cfg_want_q && !ctrl_q[`XPS_CTRL_3WIRE]) ? XPS_CFG : XPS_IDLE;
               end
            end
            XPS_CFG:
            begin
               cfg_q <= ~tick;
               if (tick)
               begin
                  state_q <= XPS_IDLE;
               end
            end
            default:
            begin
               state_q <= XPS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   // clock stays low outside a transfer, which also serves the stopped-clock style
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.din = din_q;
   assign link.cfg = ctrl_q[`XPS_CTRL_3WIRE] ? cs_n_q : cfg_q;
   assign link.mode = ctrl_q[`XPS_CTRL_MODE];
   assign link.rst = ctrl_q[`XPS_CTRL_RST];
   assign link.broadcast_input0 = ctrl_q[`XPS_CTRL_BCAST];

endmodule
`default_nettype wire

//--- bench/xps_chk.sv
// Purpose: pin-level checks on the serial link between controller and crosspoint
// Assumes: one core_clk domain, rst_n async active low
// Notes:   sees only the interface pins; routing state is judged by the bench
`timescale 1ns/10ps
`default_nettype none
module xps_chk
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic cfg,
   input wire logic mode,
   input wire logic rst,
   input wire logic broadcast_input0
);
   // ----------------------------------------------------------------
   // link timing
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_sclk_idle_low: assert property (cs_n && !mode |-> !sclk)
      else $error("serial clock moved while deselected");
   a_lead_half: assert property ($fell(cs_n) |-> (!sclk) [*8] ##1 sclk)
      else $error("first rise not one half period after select");
   a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("serial clock high phase wrong");
   a_trail_low: assert property ($rose(cs_n) |-> (!sclk) [*8])
      else $error("serial clock rose right after deselect");
   // ----------------------------------------------------------------
   // strobe and serial out
   // ----------------------------------------------------------------
   a_cfg_quiet: assert property (cfg |-> cs_n && !sclk)
      else $error("strobe high during shifting");
   // three-wire strobe follows select, so only a separate pulse is timed
   // switching to three-wire lifts the strobe to the idle select level without a pulse
   a_cfg_pulse_len: assert property ($rose(cfg) && !$rose(cs_n) |-> (cfg [*7] ##1 !cfg) or ((cfg == cs_n) [*8]))
      else $error("strobe pulse length wrong");
   a_addr_dout_zero: assert property (mode [*5] |-> !dout)
      else $error("serial out moved in addressed mode");
   a_dout_quiet: assert property ((cs_n && $stable(mode)) [*8] |=> $stable(dout))
      else $error("serial out moved while deselected");
endmodule
`default_nettype wire

//--- bench/crosspoint_serial_config_port_test.sv
// Purpose: self-checking bench for controller and crosspoint ends joined by one link
// Assumes: host timing as handed over; second crosspoint bit-banged by the bench
// Notes:   route_q packs like a frame, so a frame compares to it directly
`timescale 1ns/10ps
`default_nettype none
`include "xps_defs.svh"
module crosspoint_serial_config_port_test
   import xps_pkg::*;
;
   logic core_clk;
   logic rst_n;
   logic [`XPS_ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] q;
   xps_route_t [`XPS_OUT_N-1:0] route_q;
   xps_route_t [`XPS_OUT_N-1:0] route2_q;
   logic [`XPS_FRAME_W-1:0] shadow_q;
   logic [`XPS_FRAME_W-1:0] shadow2_q;
   logic fresh_q;
   logic fresh2_q;
   int error_cnt;
   int total_checks;

   xps_if link();
   xps_if link2();

   xps_host i_xps_host (.core_clk(core_clk), .rst_n(rst_n), .link(link.host), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   xps_dev i_xps_dev (.core_clk(core_clk), .rst_n(rst_n), .link(link.dev), .route_q(route_q),
      .shadow_q(shadow_q), .fresh_q(fresh_q));
   xps_dev i_xps_dev_2 (.core_clk(core_clk), .rst_n(rst_n), .link(link2.dev), .route_q(route2_q),
      .shadow_q(shadow2_q), .fresh_q(fresh2_q));
   xps_chk i_xps_chk (.core_clk(core_clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
      .din(link.din), .dout(link.dout), .cfg(link.cfg), .mode(link.mode), .rst(link.rst),
      .broadcast_input0(link.broadcast_input0));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic av(input logic wr, input logic [`XPS_ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] rq);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // waitrequest and read data are read as they stood just before this edge
      do
      begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 400);
      rq = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 400)
      begin
         error_cnt++;
         tally_and_finish();
      end
      // one idle edge so the next request never lands in the same step
      @(posedge core_clk);
   endtask

   task automatic wreg(input logic [`XPS_ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      av(1'b1, a, d, dummy);
   endtask

   task automatic settle;
      repeat (12) @(posedge core_clk);
   endtask

   task automatic run(input logic [31:0] cmd);
      int n;
      wreg(`XPS_REG_CMD, cmd);
      n = 0;
      q = 32'h00000001;
      while (q[0] !== 1'b0 && n < 400)
      begin
         av(1'b0, `XPS_REG_STAT, 32'h00000000, q);
         n++;
      end
      if (n >= 400)
      begin
         error_cnt++;
         tally_and_finish();
      end
      settle();
   endtask

   task automatic half_wait;
      repeat (8) @(posedge core_clk);
   endtask

   // link clock only runs inside these pulses and rests low between them;
   // data moves on the rise so it is settled at the sampling fall
   task automatic bb_pulses(input logic [15:0] d, input int n);
      for (int i = 0; i < n; i++)
      begin
         half_wait();
         link2.sclk <= 1'b1;
         link2.din <= d[i];
         half_wait();
         link2.sclk <= 1'b0;
      end
      half_wait();
      link2.din <= ~link2.din;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk("route", 32'h00008888, {16'h0000, route_q});
      chk("shadow", 32'h00000000, {16'h0000, shadow_q});
      chk("fresh", 32'h00000000, {31'h0, fresh_q});
      chk("cs_n", 32'h00000001, {31'h0, link.cs_n});
      av(1'b0, `XPS_REG_CTRL, 32'h00000000, q);
      chk("ctrl", 32'h00000000, q);
      av(1'b0, 3'h7, 32'h00000000, q);
      chk("unmapped", 32'h00000000, q);
   endtask

   task automatic t_frame;
      wreg(`XPS_REG_DATA, 32'h0000B3C5);
      run(32'h00000110);
      chk("shadow", 32'h0000B3C5, {16'h0000, shadow_q});
      chk("fresh", 32'h00000001, {31'h0, fresh_q});
      chk("route held", 32'h00008888, {16'h0000, route_q});
      run(32'h00000200);
      chk("route", 32'h0000B3C5, {16'h0000, route_q});
      chk("fresh", 32'h00000000, {31'h0, fresh_q});
   endtask

   task automatic t_force;
      wreg(`XPS_REG_CTRL, 32'h00000002);
      settle();
      chk("route rst", 32'h00008888, {16'h0000, route_q});
      wreg(`XPS_REG_CTRL, 32'h00000000);
      run(32'h00000200);
      chk("stale strobe", 32'h00008888, {16'h0000, route_q});
      wreg(`XPS_REG_CTRL, 32'h00000004);
      settle();
      chk("route bcast", 32'h00000000, {16'h0000, route_q});
      wreg(`XPS_REG_CTRL, 32'h00000006);
      settle();
      chk("route both", 32'h00008888, {16'h0000, route_q});
      wreg(`XPS_REG_CTRL, 32'h00000000);
   endtask

   task automatic t_chain;
      wreg(`XPS_REG_DATA, 32'h1E2D4A69);
      run(32'h00000120);
      chk("shadow", 32'h00001E2D, {16'h0000, shadow_q});
      av(1'b0, `XPS_REG_RX, 32'h00000000, q);
      chk("shifted out", 32'h4A69B3C5, q);
      run(32'h00000200);
      chk("route", 32'h00001E2D, {16'h0000, route_q});
   endtask

   task automatic t_addr;
      wreg(`XPS_REG_CTRL, 32'h00000001);
      wreg(`XPS_REG_DATA, 32'h00000016);
      run(32'h00000306);
      chk("route word", 32'h0000152D, {16'h0000, route_q});
      wreg(`XPS_REG_DATA, 32'h0000002D);
      run(32'h00000306);
      chk("route word2", 32'h000015BD, {16'h0000, route_q});
      chk("dout", 32'h00000000, {31'h0, link.dout});
   endtask

   task automatic t_three;
      wreg(`XPS_REG_CTRL, 32'h00000008);
      wreg(`XPS_REG_DATA, 32'h00007F01);
      run(32'h00000110);
      chk("route 3w", 32'h00007F01, {16'h0000, route_q});
      wreg(`XPS_REG_CTRL, 32'h00000000);
   endtask

   task automatic t_bitbang;
      bb_pulses(16'hFFFF, 16);
      chk("shadow2 idle", 32'h00000000, {16'h0000, shadow2_q});
      link2.cs_n <= 1'b0;
      half_wait();
      bb_pulses(16'h9A42, 16);
      link2.cs_n <= 1'b1;
      half_wait();
      link2.cfg <= 1'b1;
      half_wait();
      link2.cfg <= 1'b0;
      settle();
      chk("shadow2", 32'h00009A42, {16'h0000, shadow2_q});
      chk("route2", 32'h00009A42, {16'h0000, route2_q});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      error_cnt = 0;
      total_checks = 0;
      rst_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      link2.cs_n = 1'b1;
      link2.sclk = 1'b0;
      link2.din = 1'b0;
      link2.cfg = 1'b0;
      link2.mode = 1'b0;
      link2.rst = 1'b0;
      link2.broadcast_input0 = 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      t_reset();
      t_frame();
      t_force();
      t_chain();
      t_addr();
      t_three();
      t_bitbang();
      tally_and_finish();
   end

   initial
   begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
